// ===== core/arb_diag_pkg.sv
// package: register map, bit positions, timing and state types for the arbiter diagnostics
package arb_diag_pkg;

  // ===========================================================
  // bus and map
  // ===========================================================
  localparam int         ADDR_W   = 10;
  localparam int         NREQ     = 4;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h5c;
  localparam logic [7:0] IDX_DIAG = 8'h5e;
  localparam logic [7:0] IDX_MASK = 8'h62;
  localparam logic [7:0] IDX_TOST = 8'h63;

  // ===========================================================
  // field positions
  // ===========================================================
  localparam int DS_TOUT   = 0;
  localparam int DS_BUSY   = 1;
  localparam int DS_XARB   = 2;
  localparam int DS_HSW    = 5;
  localparam int DS_SERR   = 7;
  localparam int DS_MS0    = 8;
  localparam int DS_MS1    = 9;
  localparam int DS_PPRI   = 10;
  localparam int DS_PSEC   = 11;
  localparam int RM_REQ    = 0;
  localparam int RM_AUTO   = 6;
  localparam int DC_SERREN = 7;
  localparam int TS_REQ    = 0;

  // ===========================================================
  // timing and reset values
  // ===========================================================
  localparam int          TMO_CLKS = 16;
  localparam logic [4:0]  TMO_LAST = 5'(TMO_CLKS - 1);
  localparam logic [4:0]  CNT_ONE  = 5'h01;
  localparam logic [31:0] RD_NONE  = 32'h0000_0000;

  // ===========================================================
  // types
  // ===========================================================
  typedef struct packed {
    logic ms1;
    logic ms0;
    logic hsw;
    logic xarb;
  } pins_t;

  typedef struct packed {
    pins_t             sy1;
    pins_t             sy2;
    logic [NREQ-1:0]   mask;
    logic              auto_en;
    logic              serr_en;
    logic              psec;
    logic              ppri;
    logic              serr_flag;
    logic              to_flag;
    logic [NREQ-1:0]   to_stat;
    logic [NREQ-1:0]   gnt_q;
    logic [4:0]        cnt;
    logic              done;
    logic              serr;
    logic              ack;
    logic [31:0]       dat;
  } state_t;

endpackage : arb_diag_pkg

// ===== core/arb_diag.sv
// module: secondary arbiter diagnostic status, request masking and grant timeout
`timescale 1ns/1ps
`default_nettype none

module arb_diag (
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // wishbone slave
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic                              we_i,
  input  wire logic [arb_diag_pkg::ADDR_W-1:0]   adr_i,
  input  wire logic [3:0]                        sel_i,
  input  wire logic [31:0]                       dat_i,
  output logic      [31:0]                       dat_o,
  output logic                                   ack_o,
  // device pins
  input  wire logic                              mode_select_one_pin_i,
  input  wire logic                              mode_select_zero_pin_i,
  input  wire logic                              secondary_multifunction_pin_i,
  input  wire logic                              ext_arb_enable_pin_i,
  // internal status
  input  wire logic                              eeprom_busy_i,
  input  wire logic                              sec_master_perr_i,
  input  wire logic                              pri_master_perr_i,
  // arbiter side
  input  wire logic                              request_line_zero_i,
  input  wire logic                              request_line_one_i,
  input  wire logic                              request_line_two_i,
  input  wire logic                              request_line_three_i,
  input  wire logic [arb_diag_pkg::NREQ-1:0]     grant_i,
  input  wire logic                              frame_active_i,
  output logic      [arb_diag_pkg::NREQ-1:0]     req_used_o,
  output logic                                   serr_o
);

  // ===========================================================
  // state
  // ===========================================================
  arb_diag_pkg::state_t          s_ff;
  arb_diag_pkg::state_t          nxt_s;
  arb_diag_pkg::pins_t           pins;
  logic [arb_diag_pkg::NREQ-1:0] req_lines;
  logic [7:0]                    idx;
  logic                          req;
  logic                          wr;
  logic                          tmo;
  logic [31:0]                   rdata;

  assign pins      = '{ms1: mode_select_one_pin_i, ms0: mode_select_zero_pin_i,
                       hsw: secondary_multifunction_pin_i, xarb: ext_arb_enable_pin_i};
  assign req_lines = {request_line_three_i, request_line_two_i,
                      request_line_one_i, request_line_zero_i};
  assign idx       = adr_i[arb_diag_pkg::ADDR_W-1:2];
  assign req       = cyc_i & stb_i;

  // ===========================================================
  // request masking
  // ===========================================================
  genvar gi;
  generate
    for (gi = 0; gi < arb_diag_pkg::NREQ; gi++) begin : g_req
      assign req_used_o[gi] = req_lines[gi] & ~s_ff.mask[gi];
    end
  endgenerate

  assign ack_o  = s_ff.ack;
  assign dat_o  = s_ff.dat;
  assign serr_o = s_ff.serr;

  // ===========================================================
  // next state
  // ===========================================================
  always_comb begin
    nxt_s     = s_ff;
    rdata     = arb_diag_pkg::RD_NONE;
    tmo       = 1'b0;
    // pins pass two flops before use
    nxt_s.sy1 = pins;
    nxt_s.sy2 = s_ff.sy1;

    // register read mux; unlisted bits stay zero
    unique case (idx)
      arb_diag_pkg::IDX_CTRL: begin
        rdata[arb_diag_pkg::DC_SERREN] = s_ff.serr_en;
      end
      arb_diag_pkg::IDX_DIAG: begin
        rdata[arb_diag_pkg::DS_PSEC] = s_ff.psec;
        rdata[arb_diag_pkg::DS_PPRI] = s_ff.ppri;
        rdata[arb_diag_pkg::DS_MS1]  = s_ff.sy2.ms1;
        rdata[arb_diag_pkg::DS_MS0]  = s_ff.sy2.ms0;
        rdata[arb_diag_pkg::DS_SERR] = s_ff.serr_flag;
        rdata[arb_diag_pkg::DS_HSW]  = s_ff.sy2.hsw;
        rdata[arb_diag_pkg::DS_XARB] = s_ff.sy2.xarb;
        rdata[arb_diag_pkg::DS_BUSY] = eeprom_busy_i;
        rdata[arb_diag_pkg::DS_TOUT] = s_ff.to_flag;
      end
      arb_diag_pkg::IDX_MASK: begin
        rdata[arb_diag_pkg::RM_REQ +: arb_diag_pkg::NREQ] = s_ff.mask;
        rdata[arb_diag_pkg::RM_AUTO] = s_ff.auto_en;
      end
      arb_diag_pkg::IDX_TOST: begin
        rdata[arb_diag_pkg::TS_REQ +: arb_diag_pkg::NREQ] = s_ff.to_stat;
      end
      default: begin
        rdata = arb_diag_pkg::RD_NONE;
      end
    endcase

    // one wait state, ack drops the cycle after it is given
    nxt_s.ack = req & ~s_ff.ack;
    if (req && !s_ff.ack) begin
      nxt_s.dat = rdata;
    end

    // writes take effect on the edge that sees ack
    wr = req & we_i & s_ff.ack;
    if (wr) begin
      unique case (idx)
        arb_diag_pkg::IDX_CTRL: begin
          if (sel_i[0]) begin
            nxt_s.serr_en = dat_i[arb_diag_pkg::DC_SERREN];
          end
        end
        arb_diag_pkg::IDX_DIAG: begin
          if (sel_i[1] && dat_i[arb_diag_pkg::DS_PSEC]) begin
            nxt_s.psec = 1'b0;
          end
          if (sel_i[1] && dat_i[arb_diag_pkg::DS_PPRI]) begin
            nxt_s.ppri = 1'b0;
          end
          if (sel_i[0] && dat_i[arb_diag_pkg::DS_SERR]) begin
            nxt_s.serr_flag = 1'b0;
          end
          if (sel_i[0] && dat_i[arb_diag_pkg::DS_TOUT]) begin
            nxt_s.to_flag = 1'b0;
          end
        end
        arb_diag_pkg::IDX_MASK: begin
          if (sel_i[0]) begin
            nxt_s.mask    = dat_i[arb_diag_pkg::RM_REQ +: arb_diag_pkg::NREQ];
            nxt_s.auto_en = dat_i[arb_diag_pkg::RM_AUTO];
          end
        end
        arb_diag_pkg::IDX_TOST: begin
          if (sel_i[0]) begin
            nxt_s.to_stat = s_ff.to_stat & ~dat_i[arb_diag_pkg::TS_REQ +: arb_diag_pkg::NREQ];
          end
        end
        default: begin
          nxt_s.to_stat = nxt_s.to_stat;
        end
      endcase
    end

    // grant timer
    // done holds the timer after frame or timeout, so one grant times out once
    nxt_s.gnt_q = grant_i;
    if (grant_i != s_ff.gnt_q) begin
      nxt_s.cnt  = arb_diag_pkg::CNT_ONE;
      nxt_s.done = frame_active_i;
    end else if (frame_active_i) begin
      nxt_s.done = 1'b1;
    end else if (|grant_i && !s_ff.done) begin
      nxt_s.cnt = 5'(s_ff.cnt + 5'h01);
      if (s_ff.cnt == arb_diag_pkg::TMO_LAST) begin
        tmo        = 1'b1;
        nxt_s.done = 1'b1;
      end
    end

    // events win over software clears
    if (sec_master_perr_i) begin
      nxt_s.psec = 1'b1;
    end
    if (pri_master_perr_i) begin
      nxt_s.ppri = 1'b1;
    end
    nxt_s.serr = tmo & s_ff.serr_en;
    if (tmo) begin
      nxt_s.to_flag = 1'b1;
      nxt_s.to_stat = nxt_s.to_stat | grant_i;
      if (s_ff.serr_en) begin
        nxt_s.serr_flag = 1'b1;
      end
      if (s_ff.auto_en) begin
        nxt_s.mask = nxt_s.mask | grant_i;
      end
    end
  end

  // ===========================================================
  // registers
  // ===========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ===========================================================
  // assertions
  // ===========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic rd_diag;
  logic rd_mask;
  assign rd_diag = ack_o && !we_i && idx == arb_diag_pkg::IDX_DIAG;
  assign rd_mask = ack_o && !we_i && idx == arb_diag_pkg::IDX_MASK;

  diag_rsv_a: assert property (rd_diag |-> dat_o[15:12] == 4'h0 && !dat_o[6])
    else $error("reserved diag bits not zero");
  psec_set_a: assert property (sec_master_perr_i |=> s_ff.psec)
    else $error("secondary parity flag not set");
  psec_clr_a: assert property (wr && idx == arb_diag_pkg::IDX_DIAG && sel_i[1] && dat_i[11]
    && !sec_master_perr_i |=> !s_ff.psec)
    else $error("secondary parity flag not cleared");
  ppri_set_a: assert property (pri_master_perr_i |=> s_ff.ppri)
    else $error("primary parity flag not set");
  // a clear that meets its own event in one cycle loses
  ppri_clr_a: assert property (wr && idx == arb_diag_pkg::IDX_DIAG && sel_i[1] && dat_i[arb_diag_pkg::DS_PPRI]
    && !pri_master_perr_i |=> !s_ff.ppri)
    else $error("primary parity flag not cleared");
  serr_clr_a: assert property (wr && idx == arb_diag_pkg::IDX_DIAG && sel_i[0] && dat_i[arb_diag_pkg::DS_SERR]
    && !tmo |=> !s_ff.serr_flag)
    else $error("serr flag not cleared");
  tout_clr_a: assert property (wr && idx == arb_diag_pkg::IDX_DIAG && sel_i[0] && dat_i[arb_diag_pkg::DS_TOUT]
    && !tmo |=> !s_ff.to_flag)
    else $error("timeout flag not cleared");
  tost_clr_a: assert property (wr && idx == arb_diag_pkg::IDX_TOST && sel_i[0] && !tmo
    |=> (s_ff.to_stat & $past(dat_i[arb_diag_pkg::NREQ-1:0])) == '0)
    else $error("per-request flag not cleared");
  ctrl_rst_a: assert property ($past(rst_i) |-> !s_ff.serr_en)
    else $error("serr enable not reset");
  serr_once_a: assert property (serr_o |=> !serr_o)
    else $error("serr longer than one cycle");
  tmo_once_a: assert property (tmo |=> !tmo)
    else $error("timeout raised twice");
  req_pass_a: assert property (!s_ff.mask[1] && request_line_one_i |-> req_used_o[1])
    else $error("unmasked request dropped");
  ms1_view_a: assert property (rd_diag |-> dat_o[9] == $past(s_ff.sy2.ms1))
    else $error("mode select one mirror wrong");
  ms0_view_a: assert property (rd_diag |-> dat_o[8] == $past(s_ff.sy2.ms0))
    else $error("mode select zero mirror wrong");
  hsw_view_a: assert property (rd_diag |-> dat_o[5] == $past(s_ff.sy2.hsw))
    else $error("hot swap mirror wrong");
  xarb_view_a: assert property (rd_diag |-> dat_o[2] == $past(s_ff.sy2.xarb))
    else $error("external arbiter mirror wrong");
  busy_view_a: assert property (rd_diag |-> dat_o[1] == $past(eeprom_busy_i))
    else $error("eeprom busy mirror wrong");
  tout_set_a: assert property (tmo |=> s_ff.to_flag && dat_o == $past(dat_o) || s_ff.to_flag)
    else $error("timeout flag not set");
  serr_gate_a: assert property (tmo |=> serr_o == $past(s_ff.serr_en) && (s_ff.serr_flag || !$past(s_ff.serr_en)))
    else $error("serr on timeout wrong");
  serr_only_a: assert property (serr_o |-> $past(tmo))
    else $error("serr without timeout");
  mask_rsv_a: assert property (rd_mask |-> !dat_o[7] && !dat_o[5] && !dat_o[4])
    else $error("reserved mask bits not zero");
  auto_mask_a: assert property (tmo && s_ff.auto_en |=> (s_ff.mask & $past(grant_i)) == $past(grant_i))
    else $error("auto mask missing");
  no_auto_a: assert property (!s_ff.auto_en && !wr |=> s_ff.mask == $past(s_ff.mask))
    else $error("mask changed without auto enable");
  req_gate_a: assert property (s_ff.mask[0] |-> !req_used_o[0])
    else $error("masked request passed");
  mask_rst_a: assert property ($past(rst_i) |-> s_ff.mask == '0 && !s_ff.auto_en)
    else $error("mask not reset");
  tost_set_a: assert property (tmo |=> (s_ff.to_stat & $past(grant_i)) == $past(grant_i))
    else $error("per-request timeout missing");
  timer_len_a: assert property (tmo |-> $past(grant_i, 15) == grant_i && $past(grant_i, 16) != grant_i
    && !$past(frame_active_i))
    else $error("timeout not at sixteenth clock");

  tmo_auto_c: cover property (tmo && s_ff.auto_en && s_ff.serr_en);
  diag_rd_c:  cover property (rd_diag && dat_o[0]);
  mask_wr_c:  cover property (wr && idx == arb_diag_pkg::IDX_MASK);
  frame_c:    cover property (grant_i != s_ff.gnt_q ##3 frame_active_i);
  serr_c:     cover property (serr_o);

endmodule : arb_diag

`default_nettype wire

// ===== tb/sec_master_model.sv
// secondary bus master model: starts its frame a set number of clocks after a grant
`timescale 1ns/1ps
`default_nettype none

module sec_master_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // arbiter side
  input  wire logic [3:0] grant_i,
  input  wire logic [4:0] delay_i,
  output logic            frame_active_o
);
  logic [3:0] gnt_ff;
  logic [4:0] cnt_ff;

  // delay zero models a master that never starts; otherwise frame after delay_i clocks
  always_ff @(posedge clk_i) begin
    gnt_ff <= grant_i;
    if (rst_i || grant_i != gnt_ff) begin
      cnt_ff         <= 5'h01;
      frame_active_o <= 1'b0;
    end else begin
      if (cnt_ff != 5'h1f) cnt_ff <= cnt_ff + 5'h01;
      frame_active_o <= (delay_i != 5'h00) && (cnt_ff >= delay_i) && (grant_i != 4'h0);
    end
  end
endmodule : sec_master_model

`default_nettype wire

// ===== tb/tb.sv
// testbench: register table, pin mirrors, parity flags, request masking and grant timeout
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {
    logic        we;
    logic [9:0]  adr;
    logic [31:0] wd;
    logic [31:0] exp;
  } row_t;

  localparam logic [9:0] A_CTRL = {arb_diag_pkg::IDX_CTRL, 2'b00};
  localparam logic [9:0] A_DIAG = {arb_diag_pkg::IDX_DIAG, 2'b00};
  localparam logic [9:0] A_MASK = {arb_diag_pkg::IDX_MASK, 2'b00};
  localparam logic [9:0] A_TOST = {arb_diag_pkg::IDX_TOST, 2'b00};

  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'hf, reqs = 4'h0, grant = 4'h0, used;
  logic [31:0] wdat = 32'h0, rdat_o, rd;
  logic        ack, serr, frame, mode_one = 1'b0, mode_zero = 1'b0, mfunc = 1'b0, xarb = 1'b0;
  logic        busy = 1'b0, sperr = 1'b0, pperr = 1'b0;
  logic [4:0]  delay = 5'h00;
  int          error_cnt = 0, samples_checked = 0, cycles = 0, first, seen;
  row_t        rows [8];

  always #4 clk = ~clk;

  arb_diag dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat_o), .ack_o(ack), .mode_select_one_pin_i(mode_one),
    .mode_select_zero_pin_i(mode_zero), .secondary_multifunction_pin_i(mfunc), .ext_arb_enable_pin_i(xarb),
    .eeprom_busy_i(busy), .sec_master_perr_i(sperr), .pri_master_perr_i(pperr),
    .request_line_zero_i(reqs[0]), .request_line_one_i(reqs[1]), .request_line_two_i(reqs[2]),
    .request_line_three_i(reqs[3]), .grant_i(grant), .frame_active_i(frame), .req_used_o(used), .serr_o(serr));

  sec_master_model master (.clk_i(clk), .rst_i(rst), .grant_i(grant), .delay_i(delay), .frame_active_o(frame));

  // ==========================================================
  // checking and bus tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      error_cnt++;
    end
  endtask : chk

  // one classic cycle; ack and read data are sampled at the rising edge, the request drops right after it
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "no ack");
  endtask : wb

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdchk

  // new grant held while the master model runs; counts serr pulses mid-cycle
  task automatic grant_run(input logic [3:0] g, input logic [4:0] dl);
    first = 0; seen = 0;
    @(posedge clk);
    grant <= g; delay <= dl;
    for (int n = 1; n <= 30; n++) begin
      @(negedge clk);
      if (serr === 1'b1) begin
        seen++;
        if (first == 0) first = n;
      end
    end
    // take the grant away so no stale grant runs on into a later reset
    @(posedge clk);
    grant <= 4'h0;
  endtask : grant_run

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    rows[0] = '{1'b0, A_MASK, 32'h0, 32'h00};
    rows[1] = '{1'b0, A_DIAG, 32'h0, 32'h00};
    rows[2] = '{1'b1, A_MASK, 32'hff, 32'h0};
    rows[3] = '{1'b0, A_MASK, 32'h0, 32'h4f};
    rows[4] = '{1'b1, A_DIAG, 32'hffff, 32'h0};
    rows[5] = '{1'b0, A_DIAG, 32'h0, 32'h00};
    rows[6] = '{1'b1, A_CTRL, 32'hff, 32'h0};
    rows[7] = '{1'b0, A_CTRL, 32'h0, 32'h80};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].wd);
      if (!rows[i].we) chk(rd, rows[i].exp, "table read");
    end
    rdchk(10'h004, 32'h0, "unmapped");
    $display("test table done");
    // pin mirrors, both levels
    @(posedge clk);
    mode_one <= 1'b1; mfunc <= 1'b1; xarb <= 1'b1; busy <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(A_DIAG, 32'h226, "pins high");
    mode_one <= 1'b0; mode_zero <= 1'b1; mfunc <= 1'b0; xarb <= 1'b0; busy <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(A_DIAG, 32'h100, "pins flipped");
    $display("test pins done");
    // parity flags and their separate clears
    sperr <= 1'b1; pperr <= 1'b1;
    @(posedge clk);
    sperr <= 1'b0; pperr <= 1'b0;
    rdchk(A_DIAG, 32'hd00, "parity set");
    wb(1'b1, A_DIAG, 32'h800);
    rdchk(A_DIAG, 32'h500, "secondary cleared");
    wb(1'b1, A_DIAG, 32'h400);
    rdchk(A_DIAG, 32'h100, "primary cleared");
    $display("test parity done");
    // request masking
    reqs <= 4'hf;
    wb(1'b1, A_MASK, 32'h05);
    @(posedge clk);
    chk(32'(used), 32'ha, "req used");
    wb(1'b1, A_MASK, 32'h40);
    @(posedge clk);
    chk(32'(used), 32'hf, "req used clear");
    $display("test mask done");
    // timeout with serr and auto mask on
    grant_run(4'b0010, 5'h00);
    chk(first, 17, "serr timing");
    chk(seen, 1, "serr pulse");
    chk(32'(used), 32'hd, "auto masked");
    rdchk(A_DIAG, 32'h181, "timeout flags");
    rdchk(A_TOST, 32'h2, "per request");
    rdchk(A_MASK, 32'h42, "mask after");
    wb(1'b1, A_DIAG, 32'h81);
    wb(1'b1, A_TOST, 32'h2);
    rdchk(A_DIAG, 32'h100, "flags cleared");
    rdchk(A_TOST, 32'h0, "per request cleared");
    // master starts in time: nothing recorded
    grant_run(4'b0001, 5'h0a);
    chk(seen, 0, "in time serr");
    rdchk(A_TOST, 32'h0, "in time");
    // timeout with serr and auto mask off
    wb(1'b1, A_MASK, 32'h00);
    wb(1'b1, A_CTRL, 32'h00);
    grant_run(4'b0100, 5'h00);
    chk(seen, 0, "serr disabled");
    rdchk(A_DIAG, 32'h101, "no serr flag");
    rdchk(A_TOST, 32'h4, "request two");
    rdchk(A_MASK, 32'h0, "no auto mask");
    $display("test timeout done");
    // reset in mid-run returns the mask to zero
    wb(1'b1, A_MASK, 32'h4f);
    wb(1'b1, A_CTRL, 32'h80);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(A_MASK, 32'h0, "mask reset");
    rdchk(A_CTRL, 32'h0, "ctrl reset");
    $display("test reset done");
    give_verdict();
  end
endmodule : tb

`default_nettype wire
